/* File: bench/firmware_download_and_diag_cmd_bench.sv */
`timescale 1ns/1ps
`include "fw_download_defines.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("ERROR %0t: got %h want %h", $time, a, e); end end
module firmware_download_and_diag_cmd_bench;
  import fw_download_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [2:0]  i_addr = 3'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_security_locked = 1'b0;
  logic        i_spinup_disabled = 1'b0;
  logic        i_verify_done = 1'b1;
  logic        i_verify_ok = 1'b1;
  logic        i_reload_requested = 1'b0;
  logic        i_reload_ok = 1'b1;
  logic        i_diag_done = 1'b1;
  logic [7:0]  i_diag_code = 8'h00;
  logic        i_data_valid;
  logic [15:0] i_data;
  logic [7:0]  o_rdata;
  logic        o_data_ready;
  logic        o_image_word_valid;
  logic [15:0] o_image_word_index;
  logic        o_verify_start;
  logic        o_save_image;
  logic        o_activate;
  logic        o_discard_image;
  logic        o_spin_down;
  logic        o_diag_start;
  logic [7:0]  r;
  int          failures = 0;
  int          cmp_count = 0;
  int          ev [7];
  fw_download_cmd uut (.i_sys_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_data_valid,
    .i_data, .o_data_ready, .i_security_locked, .i_spinup_disabled, .i_verify_done, .i_verify_ok,
    .i_reload_requested, .i_reload_ok, .i_diag_done, .i_diag_code, .o_image_word_valid, .o_image_word(),
    .o_image_word_index, .o_verify_start, .o_save_image, .o_activate, .o_discard_image, .o_spin_down,
    .o_diag_start);
  host_stream_model host (.i_clk(i_sys_clk), .i_rst_n(i_reset_n), .i_ready(o_data_ready),
    .o_valid(i_data_valid), .o_data(i_data));
  initial
  begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // Pulse tally: verify, save, activate, discard, spin, diag, word
  always @(negedge i_sys_clk)
  begin
    for (int j = 0; j < 7; j++)
      ev[j] += {o_image_word_valid, o_diag_start, o_spin_down, o_discard_image, o_activate, o_save_image,
        o_verify_start} >> j & 1;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    // Let an edge pass so the next call never re-raises the strobe in this step
    @(posedge i_sys_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    d = o_rdata;
    @(posedge i_sys_clk);
  endtask
  task automatic dl(input logic [7:0] v, input logic [15:0] n, input logic [15:0] p);
    ev = '{default: 0};
    wr(`ADDR_VARIANT, v);
    wr(`ADDR_LENGTH_LOW, n[7:0]);
    wr(`ADDR_LENGTH_HIGH, n[15:8]);
    wr(`ADDR_POSITION_LOW, p[7:0]);
    wr(`ADDR_POSITION_HIGH, p[15:8]);
    wr(`ADDR_OPCODE, `OP_DOWNLOAD);
    @(posedge i_sys_clk);
    for (int k = 0; k < 3000 && o_data_ready === 1'b1; k++)
      @(posedge i_sys_clk);
    repeat (8) @(posedge i_sys_clk);
  endtask
  task automatic t_reset;
    rd(`ADDR_FAULT_FLAGS, r);
    `CHK(r, 8'h01)
    rd(`ADDR_CONTROL, r);
    `CHK(r, 8'h00)
    wr(`ADDR_LENGTH_LOW, 8'hA5);
    rd(`ADDR_LENGTH_LOW, r);
    `CHK(r, 8'hA5)
  endtask
  task automatic t_diag;
    ev = '{default: 0};
    i_diag_code <= 8'h5A;
    wr(`ADDR_OPCODE, `OP_DIAGNOSTIC);
    repeat (4) @(posedge i_sys_clk);
    `CHK(ev[5], 1)
    rd(`ADDR_FAULT_FLAGS, r);
    `CHK(r, 8'h5A)
  endtask
  task automatic t_reserved;
    logic [7:0] codes [3] = '{8'h00, 8'h05, 8'hFF};
    foreach (codes[c])
    begin
      dl(codes[c], 16'h0001, 16'h0000);
      `CHK(ev[6], 0)
      rd(`ADDR_FAULT_FLAGS, r);
      `CHK(r, 8'h04)
    end
    // Lock passes a two-flop synchroniser, so settle first
    i_security_locked <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    dl(`VAR_SINGLE, 16'h0001, 16'h0000);
    rd(`ADDR_FAULT_FLAGS, r);
    `CHK(r, 8'h04)
    i_security_locked <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
  endtask
  task automatic t_single;
    i_reload_requested <= 1'b1;
    i_reload_ok <= 1'b0;
    i_spinup_disabled <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    dl(`VAR_SINGLE, 16'h0001, 16'h0005);
    `CHK(ev[6], 256)
    `CHK(o_image_word_index, 16'h0100)
    `CHK(ev[1], 1)
    `CHK(ev[2], 1)
    `CHK(ev[4], 1)
    rd(`ADDR_FAULT_FLAGS, r);
    `CHK(r, 8'h40)
    i_reload_requested <= 1'b0;
    i_spinup_disabled <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
  endtask
  task automatic t_segments;
    dl(`VAR_SEGMENTED, 16'h0001, 16'h0000);
    `CHK(ev[6], 256)
    `CHK(ev[0], 0)
    dl(`VAR_SEGMENTED, 16'h0001, 16'h0001);
    `CHK(ev[6], 256)
    dl(`VAR_SEGMENTED, 16'h0000, 16'h0002);
    `CHK(ev[6], 0)
    `CHK(ev[0] + ev[1] + ev[2], 3)
    `CHK(ev[4], 0)
    rd(`ADDR_FAULT_FLAGS, r);
    `CHK(r, 8'h00)
  endtask
  task automatic t_break;
    dl(`VAR_SEGMENTED, 16'h0001, 16'h0000);
    dl(`VAR_SEGMENTED, 16'h0001, 16'h0002);
    `CHK(ev[3], 1)
    `CHK(ev[6], 0)
    rd(`ADDR_FAULT_FLAGS, r);
    `CHK(r, 8'h04)
  endtask
  task automatic t_other;
    dl(`VAR_SEGMENTED, 16'h0001, 16'h0000);
    t_diag();
    `CHK(ev[3], 1)
    // Diagnostic in mid-transfer must end it and still run
    wr(`ADDR_OPCODE, `OP_DOWNLOAD);
    repeat (20) @(posedge i_sys_clk);
    t_diag();
    `CHK(ev[3], 1)
    `CHK(o_data_ready, 1'b0)
  endtask
  task automatic t_swreset;
    dl(`VAR_SEGMENTED, 16'h0001, 16'h0000);
    wr(`ADDR_CONTROL, 8'h04);
    wr(`ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge i_sys_clk);
    `CHK(ev[3], 1)
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge i_sys_clk);
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end
  initial
  begin
    repeat (8) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    @(posedge i_sys_clk);
    t_reset();
    t_diag();
    t_reserved();
    t_single();
    t_segments();
    t_break();
    t_other();
    t_swreset();
    stop_test();
  end
endmodule
bind fw_download_cmd fw_download_cmd_assertions chk (.i_sys_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_data_valid, .i_data, .o_data_ready, .i_security_locked, .i_spinup_disabled, .i_verify_done,
  .i_verify_ok, .o_image_word_valid, .o_image_word, .o_save_image, .o_activate, .o_spin_down, .o_diag_start);

/* File: bench/fw_download_cmd_assertions.sv */
`timescale 1ns/1ps
`include "fw_download_defines.svh"
module fw_download_cmd_assertions
  import fw_download_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  input wire logic [2:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        i_data_valid,
  input wire logic [15:0] i_data,
  input wire logic        o_data_ready,
  input wire logic        i_security_locked,
  input wire logic        i_spinup_disabled,
  input wire logic        i_verify_done,
  input wire logic        i_verify_ok,
  input wire logic        o_image_word_valid,
  input wire logic [15:0] o_image_word,
  input wire logic        o_save_image,
  input wire logic        o_activate,
  input wire logic        o_spin_down,
  input wire logic        o_diag_start
);
  logic [7:0]  var_q;
  logic [15:0] len_q;
  logic        op_w;
  assign op_w = i_wr && i_addr == `ADDR_OPCODE;
  // Shadow of the command block, so opcode writes can be judged
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      var_q <= 8'h00;
      len_q <= 16'h0000;
    end
    else if (i_wr && i_addr == `ADDR_VARIANT)
      var_q <= i_wdata;
    else if (i_wr && i_addr == `ADDR_LENGTH_LOW)
      len_q[7:0] <= i_wdata;
    else if (i_wr && i_addr == `ADDR_LENGTH_HIGH)
      len_q[15:8] <= i_wdata;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // Variant 03h is left out: its opening also depends on continuity
  a_single_opens: assert property (op_w && i_wdata == `OP_DOWNLOAD && var_q == `VAR_SINGLE
    && len_q != 16'h0000 && !i_security_locked |=> o_data_ready) else $error("transfer did not open");
  a_zero_length: assert property (op_w && i_wdata == `OP_DOWNLOAD && len_q == 16'h0000
    |=> !o_data_ready [*2]) else $error("zero length opened a transfer");
  a_reserved_code: assert property (op_w && i_wdata == `OP_DOWNLOAD && var_q != `VAR_SINGLE
    && var_q != `VAR_SEGMENTED |=> !o_data_ready [*2]) else $error("reserved code opened a transfer");
  a_word_taken: assert property (o_image_word_valid |-> $past(i_data_valid && o_data_ready)
    && o_image_word == $past(i_data)) else $error("image word without handshake");
  a_save_verified: assert property (o_save_image |-> $past(i_verify_done && i_verify_ok))
    else $error("save without good verify");
  a_activate_follows: assert property (o_save_image |=> o_activate) else $error("no activate");
  a_spin_down: assert property (o_activate |=> o_spin_down == $past(i_spinup_disabled, 3))
    else $error("spin down wrong");
  a_diag_starts: assert property (op_w && i_wdata == `OP_DIAGNOSTIC |=> o_diag_start)
    else $error("diagnostic did not start");
  a_read_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside slot");
endmodule

/* File: bench/host_stream_model.sv */
`timescale 1ns/1ps
module host_stream_model
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic      [15:0] o_data
);
  logic [1:0]  tick_q;
  logic [15:0] word_q;
  logic [15:0] next_w;
  logic        next_v;
  // Whole words only; a sector is 256 of them
  assign next_w = (o_valid && i_ready) ? word_q + 16'h0001 : word_q;
  // Stalls one cycle in four to stress the handshake
  assign next_v = i_ready && tick_q != 2'h3;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_q <= 2'h0;
      word_q <= 16'h0000;
      o_valid <= 1'b0;
      o_data <= 16'hFFFF;
    end
    else
    begin
      tick_q <= tick_q + 2'h1;
      word_q <= next_w;
      o_valid <= next_v;
      // Idle bus shows the inverse so stale data never matches
      o_data <= next_v ? next_w : ~next_w;
    end
  end
endmodule

/* File: src/fw_download_cmd.sv */
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "fw_download_defines.svh"
module fw_download_cmd
  import fw_download_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic [2:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_data_valid,
  input  wire logic [15:0] i_data,
  output logic             o_data_ready,
  input  wire logic        i_security_locked,
  input  wire logic        i_spinup_disabled,
  input  wire logic        i_verify_done,
  input  wire logic        i_verify_ok,
  input  wire logic        i_reload_requested,
  input  wire logic        i_reload_ok,
  input  wire logic        i_diag_done,
  input  wire logic [7:0]  i_diag_code,
  output logic             o_image_word_valid,
  output logic      [15:0] o_image_word,
  output logic      [15:0] o_image_word_index,
  output logic             o_verify_start,
  output logic             o_save_image,
  output logic             o_activate,
  output logic             o_discard_image,
  output logic             o_spin_down,
  output logic             o_diag_start
);

  typedef struct packed {
    state_t      state;
    logic [7:0]  variant;
    logic [7:0]  len_lo;
    logic [7:0]  len_hi;
    logic [7:0]  pos_lo;
    logic [7:0]  pos_hi;
    logic [7:0]  dev_sel;
    logic [7:0]  fault;
    logic        err;
    logic        srst;
    logic        active;
    logic [15:0] prev_pos;
    logic [15:0] prev_cnt;
    logic [15:0] base;
    logic [15:0] sectors_left;
    logic [8:0]  words_left;
    logic [15:0] word_idx;
    logic        final_seg;
    logic        xfer_req;
    logic [7:0]  rdata;
    logic        img_valid;
    logic [15:0] img_word;
    logic        verify_start;
    logic        save;
    logic        activate;
    logic        discard;
    logic        spin_down;
    logic        diag_start;
    logic        ready;
  } st_t;

  st_t q;
  st_t d;
  logic sec_lock_m;
  logic sec_lock_s;
  logic spin_dis_m;
  logic spin_dis_s;
  reg_req_t req;
  word_t    din;

  function automatic logic [15:0] cat16(input logic [7:0] hi, input logic [7:0] lo);
    cat16 = {hi, lo};
  endfunction

  function automatic logic [7:0] status_byte(input st_t s);
    logic [7:0] b;
    b = 8'h00;
    b[`ST_OCCUPIED_BIT]  = (s.state != S_IDLE) && (s.state != S_XFER);
    b[`ST_READY_BIT]     = 1'b1;
    b[`ST_SEEK_DONE_BIT] = 1'b1;
    b[`ST_XFER_REQ_BIT]  = s.xfer_req;
    b[`ST_ERROR_BIT]     = s.err;
    status_byte = b;
  endfunction

  // Strap-like pins come from outside the clock domain
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sec_lock_m <= 1'b0;
      sec_lock_s <= 1'b0;
      spin_dis_m <= 1'b0;
      spin_dis_s <= 1'b0;
    end
    else
    begin
      sec_lock_m <= i_security_locked;
      sec_lock_s <= sec_lock_m;
      spin_dis_m <= i_spinup_disabled;
      spin_dis_s <= spin_dis_m;
    end
  end

  always_comb
  begin
    logic [15:0] len;
    logic [15:0] pos;
    logic        new_image;
    len = 16'h0000;
    pos = 16'h0000;
    new_image = 1'b0;
    req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
    din = '{valid: i_data_valid, data: i_data};
    d = q;
    d.img_valid = 1'b0;
    d.verify_start = 1'b0;
    d.save = 1'b0;
    d.activate = 1'b0;
    d.discard = 1'b0;
    d.spin_down = 1'b0;
    d.diag_start = 1'b0;
    d.rdata = 8'h00;

    if (req.rd)
    begin
      case (req.addr)
        `ADDR_FAULT_FLAGS:   d.rdata = q.fault;
        `ADDR_LENGTH_LOW:    d.rdata = q.len_lo;
        `ADDR_LENGTH_HIGH:   d.rdata = q.len_hi;
        `ADDR_POSITION_LOW:  d.rdata = q.pos_lo;
        `ADDR_POSITION_HIGH: d.rdata = q.pos_hi;
        `ADDR_DEVICE_SELECT: d.rdata = q.dev_sel;
        `ADDR_CONDITION:     d.rdata = status_byte(q);
        default:             d.rdata = 8'h00;
      endcase
    end

    // Block all but control writes while occupied, as a real task file would
    if (req.wr && (q.state == S_IDLE || q.state == S_XFER || req.addr == `ADDR_CONTROL))
    begin
      case (req.addr)
        `ADDR_VARIANT:       d.variant = req.wdata;
        `ADDR_LENGTH_LOW:    d.len_lo = req.wdata;
        `ADDR_LENGTH_HIGH:   d.len_hi = req.wdata;
        `ADDR_POSITION_LOW:  d.pos_lo = req.wdata;
        `ADDR_POSITION_HIGH: d.pos_hi = req.wdata;
        `ADDR_DEVICE_SELECT: d.dev_sel = req.wdata;
        `ADDR_CONTROL:       d.srst = req.wdata[`CTRL_SRST_BIT];
        default:             d = d;
      endcase
    end

    // Software reset drops held segments before anything else
    if (q.srst)
    begin
      d.discard = q.active;
      d.active = 1'b0;
      d.prev_pos = 16'h0000;
      d.prev_cnt = 16'h0000;
      d.state = S_IDLE;
      d.xfer_req = 1'b0;
      d.ready = 1'b0;
      d.fault = 8'h00;
      d.err = 1'b0;
    end
    else
    begin
      case (q.state)
        S_IDLE:
        begin
          if (req.wr && req.addr == `ADDR_OPCODE)
          begin
            d.fault = 8'h00;
            d.err = 1'b0;
            len = cat16(q.len_hi, q.len_lo);
            pos = cat16(q.pos_hi, q.pos_lo);
            if (req.wdata == `OP_DOWNLOAD)
            begin
              if ((q.variant != `VAR_SEGMENTED && q.variant != `VAR_SINGLE) || sec_lock_s)
              begin
                d.fault[`ERR_ABORT_BIT] = 1'b1;
                d.err = 1'b1;
              end
              else if (q.variant == `VAR_SEGMENTED && q.active
                       && pos != 16'(q.prev_pos + q.prev_cnt))
              begin
                d.fault[`ERR_ABORT_BIT] = 1'b1;
                d.err = 1'b1;
                d.discard = 1'b1;
                d.active = 1'b0;
                d.prev_pos = 16'h0000;
                d.prev_cnt = 16'h0000;
              end
              else
              begin
                // Offsets only matter for segmented mode
                new_image = (q.variant == `VAR_SINGLE) || !q.active;
                d.base = (q.variant == `VAR_SEGMENTED) ? pos : 16'h0000;
                d.discard = new_image && q.active;
                d.active = (q.variant == `VAR_SEGMENTED);
                d.prev_pos = pos;
                d.prev_cnt = len;
                // Segmented image ends on a zero-length command
                d.final_seg = (q.variant == `VAR_SINGLE) || (len == 16'h0000);
                d.sectors_left = len;
                d.words_left = `WORDS_PER_SECTOR;
                d.word_idx = 16'h0000;
                if (len == 16'h0000)
                  d.state = d.final_seg ? S_VERIFY : S_IDLE;
                else
                begin
                  d.state = S_XFER;
                  d.xfer_req = 1'b1;
                  d.ready = 1'b1;
                end
                if (d.state == S_VERIFY)
                  d.verify_start = 1'b1;
              end
            end
            else
            begin
              d.discard = q.active;
              d.active = 1'b0;
              d.prev_pos = 16'h0000;
              d.prev_cnt = 16'h0000;
              if (req.wdata == `OP_DIAGNOSTIC)
              begin
                d.state = S_DIAG;
                d.diag_start = 1'b1;
              end
            end
          end
        end
        S_XFER:
        begin
          // Data moves in whole sectors; only an opcode write or software reset ends it mid-sector
          if (din.valid && q.ready)
          begin
            d.img_valid = 1'b1;
            d.img_word = din.data;
            d.word_idx = 16'(q.word_idx + 16'h0001);
            d.words_left = 9'(q.words_left - 9'h001);
            if (q.words_left == 9'h001)
            begin
              d.words_left = `WORDS_PER_SECTOR;
              d.sectors_left = 16'(q.sectors_left - 16'h0001);
              if (q.sectors_left == 16'h0001)
              begin
                d.xfer_req = 1'b0;
                d.ready = 1'b0;
                d.state = q.final_seg ? S_VERIFY : S_IDLE;
                d.verify_start = q.final_seg;
              end
            end
          end
          if (req.wr && req.addr == `ADDR_OPCODE)
          begin
            d.discard = 1'b1;
            d.active = 1'b0;
            d.xfer_req = 1'b0;
            d.ready = 1'b0;
            d.state = S_IDLE;
            d.prev_pos = 16'h0000;
            d.prev_cnt = 16'h0000;
            // An interrupting diagnostic still runs after the discard; any other opcode just ends the transfer
            if (req.wdata == `OP_DIAGNOSTIC)
            begin
              d.state = S_DIAG;
              d.diag_start = 1'b1;
            end
          end
        end
        S_VERIFY:
        begin
          if (i_verify_done)
          begin
            if (i_verify_ok)
            begin
              d.save = 1'b1;
              d.state = S_SAVE;
            end
            else
            begin
              d.fault[`ERR_ABORT_BIT] = 1'b1;
              d.err = 1'b1;
              d.discard = 1'b1;
              d.state = S_IDLE;
            end
            d.active = 1'b0;
            d.prev_pos = 16'h0000;
            d.prev_cnt = 16'h0000;
          end
        end
        S_SAVE:
        begin
          d.activate = 1'b1;
          d.state = S_DONE;
        end
        S_DONE:
        begin
          // Reload outcome reported only when the image asked for it
          if (i_reload_requested && !i_reload_ok)
          begin
            d.fault[`ERR_UNC_BIT] = 1'b1;
            d.err = 1'b1;
          end
          d.spin_down = spin_dis_s;
          d.state = S_IDLE;
        end
        S_DIAG:
        begin
          if (i_diag_done)
          begin
            d.fault = i_diag_code;
            d.err = 1'b0;
            d.state = S_IDLE;
          end
        end
        default:
          d.state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      // Hardware reset also abandons held segments
      q <= '0;
      q.state <= S_IDLE;
      q.fault <= `DIAG_PASS_CODE;
    end
    else
      q <= d;
  end

  assign o_rdata            = q.rdata;
  assign o_data_ready       = q.ready;
  assign o_image_word_valid = q.img_valid;
  assign o_image_word       = q.img_word;
  assign o_image_word_index = q.word_idx;
  assign o_verify_start     = q.verify_start;
  assign o_save_image       = q.save;
  assign o_activate         = q.activate;
  assign o_discard_image    = q.discard;
  assign o_spin_down        = q.spin_down;
  assign o_diag_start       = q.diag_start;

endmodule

/* File: src/fw_download_defines.svh */
`ifndef FW_DOWNLOAD_DEFINES_SVH
`define FW_DOWNLOAD_DEFINES_SVH
`define ADDR_VARIANT        3'h1
`define ADDR_LENGTH_LOW     3'h2
`define ADDR_LENGTH_HIGH    3'h3
`define ADDR_POSITION_LOW   3'h4
`define ADDR_POSITION_HIGH  3'h5
`define ADDR_DEVICE_SELECT  3'h6
`define ADDR_OPCODE         3'h7
`define ADDR_FAULT_FLAGS    3'h1
`define ADDR_CONDITION      3'h7
`define ADDR_CONTROL        3'h0
`define OP_DOWNLOAD         8'h92
`define OP_DIAGNOSTIC       8'h90
`define VAR_SEGMENTED       8'h03
`define VAR_SINGLE          8'h07
`define ERR_ABORT_BIT       2
`define ERR_UNC_BIT         6
`define ST_OCCUPIED_BIT     7
`define ST_READY_BIT        6
`define ST_SEEK_DONE_BIT    4
`define ST_XFER_REQ_BIT     3
`define ST_ERROR_BIT        0
`define CTRL_SRST_BIT       2
`define WORDS_PER_SECTOR    9'h100
`define DIAG_PASS_CODE      8'h01
`endif

/* File: src/fw_download_pkg.sv */
package fw_download_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } word_t;

  typedef enum logic [5:0] {
    S_IDLE   = 6'b000001,
    S_XFER   = 6'b000010,
    S_VERIFY = 6'b000100,
    S_SAVE   = 6'b001000,
    S_DIAG   = 6'b010000,
    S_DONE   = 6'b100000
  } state_t;
endpackage
